// ### verilog/power_supply_pkg.sv
package power_supply_pkg;

  // register byte addresses
  localparam logic [7:0] sleep_one_cfg_addr      = 8'h1c;
  localparam logic [7:0] sleep_two_cfg_addr      = 8'h20;
  localparam logic [7:0] sequence_status_addr    = 8'h24;
  localparam logic [7:0] converter_control_addr  = 8'h2c;
  localparam logic [7:0] supply_status_addr      = 8'h30;
  localparam logic [7:0] core_voltage_level_addr = 8'h34;
  localparam logic [7:0] pll_supply_level_addr   = 8'h40;

  // sequence_status fields
  localparam int io_prev_bit        = 29;
  localparam int pll_prev_bit       = 28;
  localparam int analogue_prev_bit  = 25;
  localparam int core_prev_bit      = 24;
  localparam int seq_state_lsb      = 16;
  localparam int tile_clk_off_bit   = 14;
  localparam int analogue_mod_bit   = 9;
  localparam int core_mod_bit       = 8;
  localparam int io_en_bit          = 5;
  localparam int pll_en_bit         = 4;
  localparam int analogue_en_bit    = 1;
  localparam int core_en_bit        = 0;

  // sequencer state codes
  localparam logic [2:0] seq_reset        = 3'h0;
  localparam logic [2:0] seq_asleep       = 3'h1;
  localparam logic [2:0] seq_waking_one   = 3'h2;
  localparam logic [2:0] seq_waking_two   = 3'h3;
  localparam logic [2:0] seq_awake_wait   = 3'h4;
  localparam logic [2:0] seq_awake        = 3'h5;
  localparam logic [2:0] seq_sleeping_one = 3'h6;
  localparam logic [2:0] seq_sleeping_two = 3'h7;

  // converter_control fields
  localparam int pg_level_lsb       = 24;
  localparam int clear_errors_bit   = 16;
  localparam int analogue_limit_lsb = 13;
  localparam int analogue_clk_lsb   = 8;
  localparam int core_limit_lsb     = 5;
  localparam int core_clk_lsb       = 0;

  localparam logic [1:0] pg_level_reset       = 2'h2;
  localparam logic [1:0] analogue_limit_reset = 2'h0;
  localparam logic [1:0] analogue_clk_reset   = 2'h1;
  localparam logic [1:0] core_limit_reset     = 2'h0;
  localparam logic [1:0] core_clk_reset       = 2'h1;

  // supply_status fields
  localparam int osc_stable_bit        = 24;
  localparam int pll_good_bit          = 19;
  localparam int core_good_bit         = 16;
  localparam int analogue_limiting_bit = 9;
  localparam int core_limiting_bit     = 8;
  localparam int analogue_soft_bit     = 1;
  localparam int core_soft_bit         = 0;

  // sleeping-state dwell field
  localparam int          dwell_lsb   = 16;
  localparam logic [4:0]  dwell_reset = 5'h10;

endpackage : power_supply_pkg

// ### verilog/power_supply_control_status_regs.sv
// Function
// - sequence status shows the sequencer state as a 3-bit code.
// - sequence status shows supplies enabled in the previous state.
// - sequence status mirrors current clock, modulation and enable settings.
// - 2-bit power-good threshold field, reset 2, read-write.
// - clear-errors bit clears converter errors while one; software clears it.
// - 2-bit analogue converter current limit, reset 0.
// - 2-bit analogue converter switching clock select, reset 1.
// - 2-bit core converter current limit, reset 0.
// - 2-bit core converter switching clock select, reset 1.
// - supply status bit 24 shows oscillator stable.
// - supply status bits 19 and 16 show pll and core rails good.
// - supply status bits 9 and 8 show converters current limiting.
// - supply status bits 1 and 0 show converters in soft-start.
// - 7-bit core voltage code, 10 mV steps from 0.60V.
// - core and pll voltage codes reset to zero, then load the strap pins on the first clock after reset release.
// - 3-bit pll regulator code, 100 mV steps from 0.6V.
// - sleeping states dwell two to the power of the log2 field cycles.
`timescale 1ns/1ps
`default_nettype none

module power_supply_control_status_regs #(
  parameter int addr_width = 8
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // register port
  input  wire logic [addr_width-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [31:0]           reg_rdata,
  // sequencer view
  input  wire logic [2:0]            seq_state,
  input  wire logic                  io_prev_en,
  input  wire logic                  pll_prev_en,
  input  wire logic                  analogue_prev_en,
  input  wire logic                  core_prev_en,
  input  wire logic                  tile_clk_off,
  input  wire logic                  analogue_mod_pfm,
  input  wire logic                  core_mod_pfm,
  input  wire logic                  io_en,
  input  wire logic                  pll_en,
  input  wire logic                  analogue_en,
  input  wire logic                  core_en,
  output logic                       sleep_dwell_done,
  // supply health
  input  wire logic                  osc_stable,
  input  wire logic                  pll_rail_good,
  input  wire logic                  core_rail_good,
  input  wire logic                  analogue_limiting,
  input  wire logic                  core_limiting,
  input  wire logic                  analogue_soft_start,
  input  wire logic                  core_soft_start,
  // straps
  input  wire logic [6:0]            strap_core_code,
  input  wire logic [2:0]            strap_pll_code,
  // settings to the analogue side
  output logic      [1:0]            pg_level,
  output logic                       clear_errors,
  output logic      [1:0]            analogue_limit,
  output logic      [1:0]            analogue_clk_sel,
  output logic      [1:0]            core_limit,
  output logic      [1:0]            core_clk_sel,
  output logic      [6:0]            core_code,
  output logic      [2:0]            pll_code
);

  logic        reset_meta_n;
  logic        reset_sync_n;
  logic        straps_loaded;
  logic [4:0]  dwell_one;
  logic [4:0]  dwell_two;
  logic [2:0]  last_state;
  logic [31:0] dwell_count;
  logic [31:0] dwell_limit;
  logic [4:0]  dwell_sel;
  logic        in_sleep;
  logic [7:0]  addr;

  assign addr = 8'(reg_addr);

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // straps are caught by the first clocked cycle after release
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      straps_loaded <= 1'b0;
    end else begin
      straps_loaded <= 1'b1;
    end
  end

  // converter_control
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      pg_level         <= power_supply_pkg::pg_level_reset;
      clear_errors     <= 1'b0;
      analogue_limit   <= power_supply_pkg::analogue_limit_reset;
      analogue_clk_sel <= power_supply_pkg::analogue_clk_reset;
      core_limit       <= power_supply_pkg::core_limit_reset;
      core_clk_sel     <= power_supply_pkg::core_clk_reset;
    end else if (reg_write &&
                 addr == power_supply_pkg::converter_control_addr) begin
      pg_level <= reg_wdata[power_supply_pkg::pg_level_lsb +: 2];
      // held until software writes zero, no self clearing
      clear_errors <= reg_wdata[power_supply_pkg::clear_errors_bit];
      analogue_limit <=
        reg_wdata[power_supply_pkg::analogue_limit_lsb +: 2];
      analogue_clk_sel <=
        reg_wdata[power_supply_pkg::analogue_clk_lsb +: 2];
      core_limit <= reg_wdata[power_supply_pkg::core_limit_lsb +: 2];
      core_clk_sel <= reg_wdata[power_supply_pkg::core_clk_lsb +: 2];
    end
  end

  // core voltage code: strap value first, then software writes
  // no slew limiting here; ramping is left to software
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      core_code <= 7'h00;
    end else if (!straps_loaded) begin
      core_code <= strap_core_code;
    end else if (reg_write &&
                 addr == power_supply_pkg::core_voltage_level_addr) begin
      core_code <= reg_wdata[6:0];
    end
  end

  // pll regulator code, same strap handling
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      pll_code <= 3'h0;
    end else if (!straps_loaded) begin
      pll_code <= strap_pll_code;
    end else if (reg_write &&
                 addr == power_supply_pkg::pll_supply_level_addr) begin
      pll_code <= reg_wdata[2:0];
    end
  end

  // sleeping-state dwell fields
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      dwell_one <= power_supply_pkg::dwell_reset;
      dwell_two <= power_supply_pkg::dwell_reset;
    end else if (reg_write) begin
      if (addr == power_supply_pkg::sleep_one_cfg_addr) begin
        dwell_one <= reg_wdata[power_supply_pkg::dwell_lsb +: 5];
      end
      if (addr == power_supply_pkg::sleep_two_cfg_addr) begin
        dwell_two <= reg_wdata[power_supply_pkg::dwell_lsb +: 5];
      end
    end
  end

  assign in_sleep = (seq_state == power_supply_pkg::seq_sleeping_one) ||
                    (seq_state == power_supply_pkg::seq_sleeping_two);
  assign dwell_sel = (seq_state == power_supply_pkg::seq_sleeping_one) ?
                     dwell_one : dwell_two;
  assign dwell_limit = (32'h1 << dwell_sel) - 32'h1;

  // dwell timer restarts on every state change, so a field rewritten
  // mid-dwell takes effect against the count already run
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      last_state       <= power_supply_pkg::seq_reset;
      dwell_count      <= 32'h0;
      sleep_dwell_done <= 1'b0;
    end else begin
      last_state <= seq_state;
      if (seq_state != last_state) begin
        dwell_count      <= 32'h0;
        sleep_dwell_done <= 1'b0;
      end else if (in_sleep && !sleep_dwell_done) begin
        if (dwell_count == dwell_limit) begin
          sleep_dwell_done <= 1'b1;
        end else begin
          dwell_count <= dwell_count + 32'h1;
        end
      end
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      reg_rdata <= 32'h0;
      unique case (addr)
        power_supply_pkg::sequence_status_addr: begin
          reg_rdata[power_supply_pkg::io_prev_bit]       <= io_prev_en;
          reg_rdata[power_supply_pkg::pll_prev_bit]      <= pll_prev_en;
          reg_rdata[power_supply_pkg::analogue_prev_bit] <=
            analogue_prev_en;
          reg_rdata[power_supply_pkg::core_prev_bit]     <= core_prev_en;
          reg_rdata[power_supply_pkg::seq_state_lsb +: 3] <= seq_state;
          reg_rdata[power_supply_pkg::tile_clk_off_bit]  <= tile_clk_off;
          reg_rdata[power_supply_pkg::analogue_mod_bit]  <=
            analogue_mod_pfm;
          reg_rdata[power_supply_pkg::core_mod_bit]      <= core_mod_pfm;
          reg_rdata[power_supply_pkg::io_en_bit]         <= io_en;
          reg_rdata[power_supply_pkg::pll_en_bit]        <= pll_en;
          reg_rdata[power_supply_pkg::analogue_en_bit]   <= analogue_en;
          reg_rdata[power_supply_pkg::core_en_bit]       <= core_en;
        end
        power_supply_pkg::converter_control_addr: begin
          reg_rdata[power_supply_pkg::pg_level_lsb +: 2]       <= pg_level;
          reg_rdata[power_supply_pkg::clear_errors_bit]        <=
            clear_errors;
          reg_rdata[power_supply_pkg::analogue_limit_lsb +: 2] <=
            analogue_limit;
          reg_rdata[power_supply_pkg::analogue_clk_lsb +: 2]   <=
            analogue_clk_sel;
          reg_rdata[power_supply_pkg::core_limit_lsb +: 2]     <= core_limit;
          reg_rdata[power_supply_pkg::core_clk_lsb +: 2]       <=
            core_clk_sel;
        end
        power_supply_pkg::supply_status_addr: begin
          reg_rdata[power_supply_pkg::osc_stable_bit] <= osc_stable;
          reg_rdata[power_supply_pkg::pll_good_bit]   <= pll_rail_good;
          reg_rdata[power_supply_pkg::core_good_bit]  <= core_rail_good;
          reg_rdata[power_supply_pkg::analogue_limiting_bit] <=
            analogue_limiting;
          reg_rdata[power_supply_pkg::core_limiting_bit] <=
            core_limiting;
          reg_rdata[power_supply_pkg::analogue_soft_bit] <=
            analogue_soft_start;
          reg_rdata[power_supply_pkg::core_soft_bit] <=
            core_soft_start;
        end
        power_supply_pkg::core_voltage_level_addr: begin
          reg_rdata[6:0] <= core_code;
        end
        power_supply_pkg::pll_supply_level_addr: begin
          reg_rdata[2:0] <= pll_code;
        end
        power_supply_pkg::sleep_one_cfg_addr: begin
          reg_rdata[power_supply_pkg::dwell_lsb +: 5] <= dwell_one;
        end
        power_supply_pkg::sleep_two_cfg_addr: begin
          reg_rdata[power_supply_pkg::dwell_lsb +: 5] <= dwell_two;
        end
        default: begin
          reg_rdata <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : power_supply_control_status_regs

`default_nettype wire

// ### bench/psu_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module psu_regs_monitor #(
  parameter int addr_width = 8
) (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic [addr_width-1:0] reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [31:0]           reg_rdata,
  input wire logic [2:0]            seq_state,
  input wire logic                  osc_stable,
  input wire logic                  sleep_dwell_done,
  input wire logic [1:0]            pg_level,
  input wire logic                  clear_errors,
  input wire logic [6:0]            core_code,
  input wire logic [2:0]            pll_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wr_ctrl;
  assign wr_ctrl = reg_write && reg_addr == 8'h2c;
  a_pg_level_write : assert property (
    wr_ctrl |=> pg_level == $past(reg_wdata[25:24])) else $error("pg level");
  a_clear_err_write : assert property (
    wr_ctrl |=> clear_errors == $past(reg_wdata[16])) else $error("clear bit");
  a_ctrl_holds : assert property (
    !wr_ctrl |=> $stable(pg_level) && $stable(clear_errors))
    else $error("control changed without write");
  a_core_code_write : assert property (
    reg_write && reg_addr == 8'h34 |=> core_code == $past(reg_wdata[6:0]))
    else $error("core code");
  a_pll_code_write : assert property (
    reg_write && reg_addr == 8'h40 |=> pll_code == $past(reg_wdata[2:0]))
    else $error("pll code");
  a_ro_write_void : assert property (
    reg_write && reg_addr == 8'h30 |=> $stable(core_code) && $stable(pll_code))
    else $error("status write changed codes");
  a_state_read : assert property (
    reg_read && reg_addr == 8'h24 |=>
      reg_rdata[18:16] == $past(seq_state) && reg_rdata[31:30] == 2'h0)
    else $error("state readback");
  a_osc_read : assert property (
    reg_read && reg_addr == 8'h30 |=> reg_rdata[24] == $past(osc_stable))
    else $error("oscillator flag");
  a_dwell_restart : assert property (
    $changed(seq_state) |=> !sleep_dwell_done) else $error("dwell not cleared");
endmodule : psu_regs_monitor
bind power_supply_control_status_regs psu_regs_monitor #(
  .addr_width(addr_width)
) mon (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .seq_state(seq_state), .osc_stable(osc_stable),
  .sleep_dwell_done(sleep_dwell_done), .pg_level(pg_level),
  .clear_errors(clear_errors), .core_code(core_code), .pll_code(pll_code));
`default_nettype wire

// ### bench/power_supply_control_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module power_supply_control_status_regs_test;
  logic        clk, resetn, reg_write, reg_read, sleep_dwell_done, clear_errors;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0]  seq_state, strap_pll, pll_code;
  logic [3:0]  prev;
  logic [6:0]  cur, health, strap_core, core_code;
  logic [1:0]  k, pg_level, analogue_limit, analogue_clk_sel;
  logic [1:0]  core_limit, core_clk_sel;
  int          n_mismatch, n_tests, cycles, cnt;

  power_supply_control_status_regs uut (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .seq_state(seq_state),
    .io_prev_en(prev[3]), .pll_prev_en(prev[2]), .analogue_prev_en(prev[1]),
    .core_prev_en(prev[0]), .tile_clk_off(cur[6]), .analogue_mod_pfm(cur[5]),
    .core_mod_pfm(cur[4]), .io_en(cur[3]), .pll_en(cur[2]),
    .analogue_en(cur[1]), .core_en(cur[0]),
    .sleep_dwell_done(sleep_dwell_done), .osc_stable(health[6]),
    .pll_rail_good(health[5]), .core_rail_good(health[4]),
    .analogue_limiting(health[3]), .core_limiting(health[2]),
    .analogue_soft_start(health[1]), .core_soft_start(health[0]),
    .strap_core_code(strap_core), .strap_pll_code(strap_pll),
    .pg_level(pg_level), .clear_errors(clear_errors),
    .analogue_limit(analogue_limit), .analogue_clk_sel(analogue_clk_sel),
    .core_limit(core_limit), .core_clk_sel(core_clk_sel),
    .core_code(core_code), .pll_code(pll_code));

  function automatic logic [31:0] seq_word(logic [2:0] s, logic [3:0] p,
                                           logic [6:0] c);
    return {2'h0, p[3:2], 2'h0, p[1:0], 5'h0, s, 1'h0, c[6], 4'h0, c[5:4],
            2'h0, c[3:2], 2'h0, c[1:0]};
  endfunction : seq_word

  function automatic logic [31:0] health_word(logic [6:0] h);
    return {7'h0, h[6], 4'h0, h[5], 2'h0, h[4], 6'h0, h[3:2], 6'h0, h[1:0]};
  endfunction : health_word

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e);
    @(posedge clk);
  endtask : rd

  // count edges from the state change until the dwell flag shows
  task automatic dwell(input logic [2:0] s, input int n);
    seq_state <= 3'h5;
    repeat (3) @(posedge clk);
    seq_state <= s;
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (sleep_dwell_done !== 1'b1 && cnt < 100);
    // counted from the edge that drives the new state: 2^n + 1 edges
    `CHK(cnt, (1 << n) + 1);
    @(posedge clk);
  endtask : dwell

  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {prev, cur, health} = '0;
    seq_state = 3'h5;
    strap_core = 7'h2a;
    strap_pll = 3'h5;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h2c, 32'h0200_0101);
    rd(8'h34, 32'h0000_002a);
    rd(8'h40, 32'h0000_0005);
    rd(8'h1c, 32'h0010_0000);
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      d = {6'h0, k, 7'h0, k[0], 1'h0, k, 3'h0, k, 1'h0, k, 3'h0, k};
      wr(8'h2c, d | ~32'h0301_6363);
      `CHK({pg_level, clear_errors}, {k, k[0]});
      `CHK({analogue_limit, analogue_clk_sel}, {k, k});
      `CHK({core_limit, core_clk_sel}, {k, k});
      rd(8'h2c, d);
    end
    wr(8'h24, 32'hffff_ffff);
    wr(8'h30, 32'hffff_ffff);
    wr(8'h38, 32'h0000_0000);
    rd(8'h38, 32'h0000_0000);
    rd(8'h2c, d);
    // the clear bit is not self clearing, so software drops it again
    wr(8'h2c, d & ~32'h0001_0000);
    `CHK(clear_errors, 1'b0);
    rd(8'h2c, d & ~32'h0001_0000);
    // ramp one code per 27 cycles (1.08 us) to keep the rail slew in bounds
    for (int i = 8'h2b; i <= 8'h46; i++) begin
      wr(8'h34, 32'hffff_ff80 | i);
      repeat (25) @(posedge clk);
    end
    `CHK(core_code, 7'h46);
    rd(8'h34, 32'h0000_0046);
    wr(8'h40, 32'hffff_fff6);
    wr(8'h40, 32'hffff_fff7);
    `CHK(pll_code, 3'h7);
    rd(8'h40, 32'h0000_0007);
    for (int i = 0; i < 8; i++) begin
      seq_state <= 3'(i);
      prev <= 4'(i * 5);
      cur <= 7'(i * 37);
      health <= 7'h1 << i;
      @(posedge clk);
      rd(8'h24, seq_word(seq_state, prev, cur));
      rd(8'h30, health_word(health));
    end
    wr(8'h1c, 32'h0002_0000);
    wr(8'h20, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    dwell(3'h6, 2);
    dwell(3'h7, 0);
    results();
  end
endmodule : power_supply_control_status_regs_test
`default_nettype wire
